/* File: hw/timer16_pkg.sv */
/*
 constants shared by the 16-bit compare/capture timer files.
 assumes an 8-bit cpu data bus with 16-bit byte addresses.
*/
// Operation
// - 16-bit up-counter advances on each selected count tick, free running.
// - reset clears the counter to zero; counting then resumes.
// - counter equal to compare value raises the compare interrupt request.
// - compare value takes any 16-bit value; reset sets it to all ones.
// - capture trigger copies the count into the capture register, held.
// - edge field: 00 off, 01 rising, 10 falling, 11 both edges.
// - capture register contents after reset carry no defined meaning.
// - mode control resets to zero; accepts single-bit and whole-byte writes.
// - invert bit lets a match toggle output data; top data bit read-only.
// - wrap sets the overflow flag; only software clears it, writing zero.
// - clock field: 00 other timer irq, 01 main, 10 main/4, 11 main/32.
// - output enable routes timer output data to the shared pin.
// - port direction resets to ones; pin bit 0 drives, 1 is input.
// - a counter read buffer latches the count so reads stay consistent.
// - count after stop-mode release is undefined; no defined value expected.
// - a match neither clears nor stops the counter.
// - enabled inverting output toggles per match, starting low when enabled.
// - capture register takes the count within two clocks of the edge; here it loads on the fourth clock after the pin change.
// - low-byte read freezes the buffer; high-byte read releases it.
package timer16_pkg;
    localparam logic [15:0] ADDR_PORT3_DIR = 16'hFF23;
    localparam logic [15:0] ADDR_TMC = 16'hFF48;
    localparam logic [15:0] ADDR_CMP_LO = 16'hFF4C;
    localparam logic [15:0] ADDR_CMP_HI = 16'hFF4D;
    localparam logic [15:0] ADDR_CNT_LO = 16'hFF4E;
    localparam logic [15:0] ADDR_CNT_HI = 16'hFF4F;
    localparam logic [15:0] ADDR_CAP_LO = 16'hFF50;
    localparam logic [15:0] ADDR_CAP_HI = 16'hFF51;

    localparam int TOD_BIT = 7;
    localparam int TOF_BIT = 6;
    localparam int CPT_HI_BIT = 5;
    localparam int CPT_LO_BIT = 4;
    localparam int TOC_BIT = 3;
    localparam int TCL_HI_BIT = 2;
    localparam int TCL_LO_BIT = 1;
    localparam int TOE_BIT = 0;
    localparam int SHARED_PIN_DIR_BIT = 3;

    localparam logic [7:0] TMC_RST = 8'h00;
    localparam logic [7:0] TMC_WRITABLE = 8'h3F;
    localparam logic [7:0] PORT3_DIR_RST = 8'hFF;
    localparam logic [7:0] PORT3_DIR_FIXED = 8'hE0;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CAP_RST = 16'h0000;
    localparam logic [7:0] RDATA_RST = 8'h00;

    localparam logic [1:0] CLK_OTHER = 2'h0;
    localparam logic [1:0] CLK_FX = 2'h1;
    localparam logic [1:0] CLK_DIV4 = 2'h2;
    localparam logic [1:0] CLK_DIV32 = 2'h3;
    localparam logic [4:0] PRESCALE_RST = 5'h00;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage : timer16_pkg

/* File: hw/timer_link_if.sv */
/*
 carries clock select, capture edge select and the resulting strobes
 between the timer core and its tick and edge helpers.
 assumes all parties run on the same system clock.
*/
`timescale 1ns/1ps
interface timer_link_if;
    logic [1:0] clk_sel;
    logic [1:0] edge_sel;
    logic other_irq;
    logic pin_in;
    logic count_tick;
    logic capture_stb;
    modport tick_gen (input clk_sel, input other_irq, output count_tick);
    modport edge_det (input edge_sel, input pin_in, output capture_stb);
    modport core (
        output clk_sel,
        output edge_sel,
        output other_irq,
        output pin_in,
        input count_tick,
        input capture_stb
    );
endinterface : timer_link_if

/* File: hw/count_tick_gen.sv */
/*
 count clock prescaler: one tick pulse per selected count clock.
 assumes other_irq is a one-cycle pulse synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module count_tick_gen (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    timer_link_if.tick_gen lk
);
    import timer16_pkg::*;

    typedef struct packed {
        logic [4:0] prescale;
    } tick_state_t;

    tick_state_t st_r;
    tick_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prescale = st_r.prescale + 5'h01;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r.prescale <= PRESCALE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // free-running prescaler: a select change may shorten the first tick
    always_comb begin
        case (lk.clk_sel)
            CLK_OTHER: lk.count_tick = lk.other_irq;
            CLK_FX: lk.count_tick = 1'b1;
            CLK_DIV4: begin
                lk.count_tick = (st_r.prescale[1:0] == DIV4_LAST);
            end
            CLK_DIV32: lk.count_tick = (st_r.prescale == DIV32_LAST);
            default: lk.count_tick = 1'b0;
        endcase
    end
endmodule : count_tick_gen

/* File: hw/capture_edge_det.sv */
/*
 capture pin synchroniser and edge qualifier.
 assumes the capture pin may change at any time relative to sys_clk_i.
*/
`timescale 1ns/1ps
module capture_edge_det (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    timer_link_if.edge_det lk
);
    import timer16_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic stb;
    } edge_state_t;

    edge_state_t st_r;
    edge_state_t st_nxt;
    logic rise;
    logic fall;

    always_comb begin
        st_nxt = st_r;
        rise = st_r.sync2 & ~st_r.prev;
        fall = ~st_r.sync2 & st_r.prev;
        st_nxt.sync1 = lk.pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        case (lk.edge_sel)
            EDGE_OFF: st_nxt.stb = 1'b0;
            EDGE_RISE: st_nxt.stb = rise;
            EDGE_FALL: st_nxt.stb = fall;
            EDGE_BOTH: st_nxt.stb = rise | fall;
            default: st_nxt.stb = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // single-cycle strobe per edge
    assign lk.capture_stb = st_r.stb;
endmodule : capture_edge_det

/* File: hw/timer16_compare_capture.sv */
/*
 16-bit free-running timer with compare, toggle output, capture,
 overflow flag and counter read buffer, on an 8-bit cpu register bus.
 assumes bus strobes are one-cycle pulses synchronous to sys_clk_i and
 16-bit quantities are read low byte first.
*/
`timescale 1ns/1ps
module timer16_compare_capture (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_wmask_i,
    output logic [7:0] bus_rdata_o,
    input wire logic other_timer_irq_i,
    input wire logic capture_input_pin_i,
    input wire logic shared_pin_latch_i,
    output logic timer_output_pin_o,
    output logic timer_output_pin_oe_n_o,
    output logic [7:0] port3_direction_o,
    output logic compare_match_irq_o
);
    import timer16_pkg::*;

    typedef struct packed {
        logic [7:0] tmc;
        logic [7:0] dir;
        logic [15:0] cmp;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic [15:0] rbuf;
        logic frozen;
        logic match_prev;
        logic irq;
        logic pin;
        logic pin_oe_n;
        logic [7:0] rdata;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;
    timer_link_if lk ();

    logic match;
    logic match_rise;
    logic [7:0] tmc_w;
    logic [7:0] dir_w;
    logic [7:0] rd_byte;

    assign lk.clk_sel = {st_r.tmc[TCL_HI_BIT], st_r.tmc[TCL_LO_BIT]};
    assign lk.edge_sel = {st_r.tmc[CPT_HI_BIT], st_r.tmc[CPT_LO_BIT]};
    assign lk.other_irq = other_timer_irq_i;
    assign lk.pin_in = capture_input_pin_i;

    count_tick_gen u_tick (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .lk(lk.tick_gen)
    );

    capture_edge_det u_edge (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .lk(lk.edge_det)
    );

    always_comb begin
        st_nxt = st_r;
        match = (st_r.cnt == st_r.cmp);
        // a compare rewrite onto the live count also raises the request
        match_rise = match & ~st_r.match_prev;
        tmc_w = (st_r.tmc & ~bus_wmask_i) | (bus_wdata_i & bus_wmask_i);
        dir_w = (st_r.dir & ~bus_wmask_i) | (bus_wdata_i & bus_wmask_i);
        rd_byte = 8'h00;

        // counting never stops on a match
        if (lk.count_tick) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        st_nxt.match_prev = match;
        st_nxt.irq = match_rise;

        // register writes; bit writes use a one-hot mask
        if (bus_wr_i) begin
            case (bus_addr_i)
                ADDR_TMC: begin
                    st_nxt.tmc = (st_r.tmc & ~TMC_WRITABLE)
                               | (tmc_w & TMC_WRITABLE);
                    // software may only clear the flag
                    st_nxt.tmc[TOF_BIT] = st_r.tmc[TOF_BIT]
                        & ~(bus_wmask_i[TOF_BIT] & ~bus_wdata_i[TOF_BIT]);
                end
                ADDR_PORT3_DIR: begin
                    st_nxt.dir = dir_w | PORT3_DIR_FIXED;
                end
                ADDR_CMP_LO: begin
                    st_nxt.cmp[7:0] = bus_wdata_i;
                end
                ADDR_CMP_HI: begin
                    st_nxt.cmp[15:8] = bus_wdata_i;
                end
                default: begin
                end
            endcase
        end

        // wrap sets the flag; set wins over a same-cycle clear
        if (lk.count_tick && (st_r.cnt == CNT_MAX)) begin
            st_nxt.tmc[TOF_BIT] = 1'b1;
        end

        // output starts low whenever output is newly enabled
        // cleared in the enabling write itself, so the pin never shows
        // the stale data level for a cycle
        if (st_nxt.tmc[TOE_BIT] && !st_r.tmc[TOE_BIT]) begin
            st_nxt.tmc[TOD_BIT] = 1'b0;
        end else if (match_rise && st_r.tmc[TOC_BIT]) begin
            st_nxt.tmc[TOD_BIT] = ~st_r.tmc[TOD_BIT];
        end

        // capture strobe arrives one clock after the synchronised edge
        if (lk.capture_stb) begin
            st_nxt.cap = st_r.cnt;
        end

        // read buffer follows the count until a low-byte read freezes it
        if (!st_r.frozen) begin
            st_nxt.rbuf = st_r.cnt;
        end

        if (bus_rd_i) begin
            case (bus_addr_i)
                ADDR_TMC: rd_byte = st_r.tmc;
                ADDR_PORT3_DIR: rd_byte = st_r.dir;
                ADDR_CMP_LO: rd_byte = st_r.cmp[7:0];
                ADDR_CMP_HI: rd_byte = st_r.cmp[15:8];
                ADDR_CNT_LO: begin
                    rd_byte = st_r.frozen ? st_r.rbuf[7:0] : st_r.cnt[7:0];
                    st_nxt.frozen = 1'b1;
                    if (!st_r.frozen) begin
                        st_nxt.rbuf = st_r.cnt;
                    end
                end
                ADDR_CNT_HI: begin
                    // high byte alone, without the low read, is stale
                    rd_byte = st_r.rbuf[15:8];
                    st_nxt.frozen = 1'b0;
                end
                ADDR_CAP_LO: rd_byte = st_r.cap[7:0];
                ADDR_CAP_HI: rd_byte = st_r.cap[15:8];
                default: rd_byte = 8'h00;
            endcase
            st_nxt.rdata = rd_byte;
        end

        // timer data drives the pin only when enabled
        st_nxt.pin = st_nxt.tmc[TOE_BIT] ? st_nxt.tmc[TOD_BIT]
                                         : shared_pin_latch_i;
        st_nxt.pin_oe_n = st_nxt.dir[SHARED_PIN_DIR_BIT];
    end

    // no stop mode here; the count is simply reset-defined
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r.tmc <= TMC_RST;
            st_r.dir <= PORT3_DIR_RST;
            st_r.cmp <= CMP_RST;
            st_r.cnt <= CNT_RST;
            st_r.cap <= CAP_RST;
            st_r.rbuf <= CNT_RST;
            st_r.frozen <= 1'b0;
            st_r.match_prev <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.pin <= 1'b0;
            st_r.pin_oe_n <= 1'b1;
            st_r.rdata <= RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata_o = st_r.rdata;
    assign timer_output_pin_o = st_r.pin;
    assign timer_output_pin_oe_n_o = st_r.pin_oe_n;
    assign port3_direction_o = st_r.dir;
    assign compare_match_irq_o = st_r.irq;
endmodule : timer16_compare_capture

/* File: tb/pin_partner.sv */
/*
 capture trigger source and load on the shared timer pin.
 assumes the timer enables its driver with an active-low enable.
*/
`timescale 1ns/1ps
module pin_partner (
    input wire logic sys_clk_i,
    input wire logic out_i,
    input wire logic oe_n_i,
    output logic pin_o
);
    logic drive_r = 1'b0;
    // the source only drives while the pin is an input
    assign pin_o = oe_n_i ? drive_r : out_i;
    task automatic set_level(input logic v);
        @(posedge sys_clk_i);
        drive_r <= v;
    endtask : set_level
endmodule : pin_partner

/* File: tb/timer16_cc_monitor.sv */
/*
 port assertions for the compare/capture timer.
 assumes one clock domain; bound to the timer top.
*/
`timescale 1ns/1ps
module timer16_cc_monitor
    import timer16_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_wmask_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic other_timer_irq_i,
    input wire logic capture_input_pin_i,
    input wire logic shared_pin_latch_i,
    input wire logic timer_output_pin_o,
    input wire logic timer_output_pin_oe_n_o,
    input wire logic [7:0] port3_direction_o,
    input wire logic compare_match_irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence dir_wr;
        bus_wr_i && bus_addr_i == ADDR_PORT3_DIR && bus_wmask_i == 8'hFF;
    endsequence
    sequence dir_rd;
        bus_rd_i && bus_addr_i == ADDR_PORT3_DIR;
    endsequence
    a_irq_pulse: assert property (
        compare_match_irq_o |=> !compare_match_irq_o)
        else $error("compare irq held past one cycle");
    a_dir_top_ones: assert property (
        port3_direction_o[7:5] == 3'b111)
        else $error("direction top bits not ones");
    a_dir_byte_wr: assert property (
        dir_wr |=> port3_direction_o == ($past(bus_wdata_i) | PORT3_DIR_FIXED))
        else $error("direction byte write lost");
    a_dir_bit_wr: assert property (
        bus_wr_i && bus_addr_i == ADDR_PORT3_DIR && bus_wmask_i == 8'h08
        |=> port3_direction_o[3] == $past(bus_wdata_i[3])
        && $stable(port3_direction_o[2:0]))
        else $error("direction bit write wrong");
    a_dir_readback: assert property (
        dir_rd |=> bus_rdata_o == $past(port3_direction_o))
        else $error("direction read mismatch");
    a_dir_wr_rd: assert property (
        dir_wr ##2 dir_rd
        |=> bus_rdata_o == ($past(bus_wdata_i, 3) | PORT3_DIR_FIXED))
        else $error("direction write then read mismatch");
    a_oe_follows_dir: assert property (
        timer_output_pin_oe_n_o == port3_direction_o[SHARED_PIN_DIR_BIT])
        else $error("pin enable differs from direction bit");
    a_rdata_holds: assert property (
        !bus_rd_i |=> $stable(bus_rdata_o))
        else $error("read data changed without a read");
    c_irq: cover property (compare_match_irq_o);
endmodule : timer16_cc_monitor

bind timer16_compare_capture timer16_cc_monitor mon_u (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_wmask_i(bus_wmask_i),
    .bus_rdata_o(bus_rdata_o),
    .other_timer_irq_i(other_timer_irq_i),
    .capture_input_pin_i(capture_input_pin_i),
    .shared_pin_latch_i(shared_pin_latch_i),
    .timer_output_pin_o(timer_output_pin_o),
    .timer_output_pin_oe_n_o(timer_output_pin_oe_n_o),
    .port3_direction_o(port3_direction_o),
    .compare_match_irq_o(compare_match_irq_o)
);

/* File: tb/timer16_compare_capture_tb_top.sv */
/*
 self-checking bench for the compare/capture timer.
 assumes the package, interface and design files are compiled first.
*/
`timescale 1ns/1ps
module timer16_compare_capture_tb_top;
    import timer16_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [15:0] bus_addr_i = 16'h0000;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [7:0] bus_wdata_i = 8'h00;
    logic [7:0] bus_wmask_i = 8'h00;
    logic other_timer_irq_i = 1'b0;
    logic shared_pin_latch_i = 1'b0;
    logic capture_input_pin_i;
    logic [7:0] bus_rdata_o;
    logic timer_output_pin_o;
    logic timer_output_pin_oe_n_o;
    logic [7:0] port3_direction_o;
    logic compare_match_irq_o;
    int errors = 0;
    int checks = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    timer16_compare_capture dut_u (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
        .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
        .bus_wmask_i(bus_wmask_i), .bus_rdata_o(bus_rdata_o),
        .other_timer_irq_i(other_timer_irq_i),
        .capture_input_pin_i(capture_input_pin_i),
        .shared_pin_latch_i(shared_pin_latch_i),
        .timer_output_pin_o(timer_output_pin_o),
        .timer_output_pin_oe_n_o(timer_output_pin_oe_n_o),
        .port3_direction_o(port3_direction_o),
        .compare_match_irq_o(compare_match_irq_o)
    );
    pin_partner src_u (.sys_clk_i(sys_clk_i), .out_i(timer_output_pin_o),
        .oe_n_i(timer_output_pin_oe_n_o), .pin_o(capture_input_pin_i));
    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic [7:0] m);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wmask_i <= m;
        bus_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd_i <= 1'b0;
        #1;
        d = bus_rdata_o;
    endtask : rd
    // low byte first: the low read freezes the buffer
    task automatic rd16(input logic [15:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 16'h0001, v[15:8]);
    endtask : rd16
    task automatic wait_irq(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge sys_clk_i);
            #1;
            if (compare_match_irq_o === 1'b1) break;
        end
        if (i == lim) begin
            $display("BAD compare_match_irq_o expected 1 seen 0");
            errors++;
            summarize();
        end
    endtask : wait_irq
    task automatic pin_after(input int n, input logic e);
        repeat (n) @(posedge sys_clk_i);
        #1;
        chk("timer_output_pin_o", {15'h0, e}, {15'h0, timer_output_pin_o});
    endtask : pin_after
    task automatic t_reset();
        logic [15:0] v;
        rd16(ADDR_CMP_LO, v);
        chk("compare_value", CMP_RST, v);
        rd16(ADDR_CNT_LO, v);
        chk("free_running_count", CNT_RST, v);
        rd(ADDR_TMC, v[7:0]);
        chk("timer_mode_control", 16'h0000, v & 16'h00FF);
        rd(ADDR_PORT3_DIR, v[7:0]);
        chk("port3_direction", 16'h00FF, v & 16'h00FF);
        wr(ADDR_PORT3_DIR, 8'h15, 8'hFF);
        rd(ADDR_PORT3_DIR, v[7:0]);
        chk("port3_direction", 16'h00F5, v & 16'h00FF);
        rd(16'hFF00, v[7:0]);
        chk("unmapped", 16'h0000, v & 16'h00FF);
    endtask : t_reset
    task automatic t_other_clock();
        logic [15:0] v;
        repeat (3) begin
            @(posedge sys_clk_i);
            other_timer_irq_i <= 1'b1;
            @(posedge sys_clk_i);
            other_timer_irq_i <= 1'b0;
        end
        rd16(ADDR_CNT_LO, v);
        chk("count_other_irq", 16'h0003, v);
    endtask : t_other_clock
    task automatic t_compare();
        logic [7:0] d;
        wr(ADDR_PORT3_DIR, 8'h00, 8'h08);
        // inversion is still off and the count idle while compare changes
        wr(ADDR_CMP_LO, 8'h40, 8'hFF);
        wr(ADDR_CMP_HI, 8'h00, 8'hFF);
        wr(ADDR_TMC, 8'h0B, 8'hFF);
        wait_irq(200);
        pin_after(1, 1'b1);
        wr(ADDR_TMC, 8'h00, 8'h80);
        rd(ADDR_TMC, d);
        chk("output_data_bit", 16'h0001, {15'h0, d[TOD_BIT]});
        wr(ADDR_TMC, 8'h00, 8'h01);
        pin_after(2, 1'b0);
        @(posedge sys_clk_i);
        shared_pin_latch_i <= 1'b1;
        pin_after(3, 1'b1);
        @(posedge sys_clk_i);
        shared_pin_latch_i <= 1'b0;
        wr(ADDR_TMC, 8'h01, 8'h01);
        pin_after(0, 1'b0);
        pin_after(3, 1'b0);
        wait_irq(70000);
        pin_after(1, 1'b1);
        rd(ADDR_TMC, d);
        chk("overflow_flag", 16'h0001, {15'h0, d[TOF_BIT]});
        wr(ADDR_TMC, 8'h00, 8'h40);
        rd(ADDR_TMC, d);
        chk("overflow_flag", 16'h0000, {15'h0, d[TOF_BIT]});
    endtask : t_compare
    task automatic t_read_buffer();
        logic [15:0] v1;
        logic [15:0] v2;
        rd16(ADDR_CNT_LO, v1);
        repeat (10) @(posedge sys_clk_i);
        rd16(ADDR_CNT_LO, v2);
        chk("count_read_pair", 16'h000E, v2 - v1);
    endtask : t_read_buffer
    task automatic capture_edge(input logic lvl, input logic want);
        logic [15:0] old;
        logic [15:0] c;
        logic [15:0] v;
        logic in_window;
        rd16(ADDR_CAP_LO, old);
        rd16(ADDR_CNT_LO, c);
        src_u.set_level(lvl);
        repeat (20) @(posedge sys_clk_i);
        rd16(ADDR_CAP_LO, v);
        // seven edges pass from the count read to the capture: at most
        // two ticks of the divide-by-4 count clock
        in_window = ((v - c) <= 16'h0002);
        if (want) begin
            chk("capture_window", 16'h0001, {15'h0, in_window});
        end else begin
            chk("capture_hold", old, v);
        end
        repeat (20) @(posedge sys_clk_i);
        rd16(ADDR_CAP_LO, old);
        chk("capture_once", v, old);
    endtask : capture_edge
    task automatic t_capture();
        logic [1:0] m;
        wr(ADDR_PORT3_DIR, 8'h08, 8'h08);
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            // divided clock: the two-tick capture window check fails at the undivided rate
            wr(ADDR_TMC, {2'b00, m, 4'h4}, 8'hFF);
            capture_edge(1'b1, m[0]);
            capture_edge(1'b0, m[1]);
        end
    endtask : t_capture
    initial begin
        repeat (16) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_other_clock();
        t_compare();
        t_read_buffer();
        t_capture();
        // a reset in mid-run must bring back the compare, count, mode and direction reset values
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        repeat (16) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        summarize();
    end
endmodule : timer16_compare_capture_tb_top
